// File: src/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_CH0_LOW   8'h60
`define IDX_CH0_HIGH  8'h61
`define IDX_CH1_LOW   8'h62
`define IDX_CH1_HIGH  8'h63
`define IDX_CH2_LOW   8'h64
`define IDX_CH2_HIGH  8'h65
`define IDX_CH3_LOW   8'h66
`define IDX_CH3_HIGH  8'h67
`define IDX_MODE      8'h68

// converter_mode_register fields
`define MODE_END_BIT     7
`define MODE_BUSY_BIT    6
`define MODE_REPEAT_BIT  5
`define MODE_SCAN_BIT    4
`define MODE_SPEED_BIT   3
`define MODE_START_BIT   2
`define MODE_CH_HI       1
`define MODE_CH_LO       0
`define MODE_CH_RESET    2'h0

// low result byte filler bits 5..0
`define LOW_FILL         6'h3f

// ladder clock cycles spent on each of the ten bit trials
`define FAST_STEP_CYCLES 8'h04
`define SLOW_STEP_CYCLES 8'h10

`endif

// File: src/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef logic [9:0] result_type;
  typedef logic [1:0] chan_type;
  typedef logic [7:0] byte_type;

  typedef enum logic {
    st_idle,
    st_convert
  } seq_state_type;

endpackage

// File: src/sar_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface sar_link_if;
  import adc_seq_pkg::*;

  logic       start;
  logic       abort;
  logic       slow;
  logic       done;
  result_type result;

  modport seq (
    output start,
    output abort,
    output slow,
    input  done,
    input  result
  );

  modport engine (
    input  start,
    input  abort,
    input  slow,
    output done,
    output result
  );
endinterface

`default_nettype wire

// File: src/sar_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

module sar_engine (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    comparator_out,
  output logic [9:0]                   ladder_code,
  output logic                         comparator_enable,
  sar_link_if.engine                   link
);
  import adc_seq_pkg::*;

  logic       comp_meta_q;
  logic       comp_q;
  logic       active_q;
  logic [3:0] bit_q;
  logic [7:0] cnt_q;
  logic [9:0] code_q;
  logic [9:0] result_q;
  logic       done_q;

  wire  [7:0] step_len = link.slow ? `SLOW_STEP_CYCLES : `FAST_STEP_CYCLES;
  wire        step_end = active_q && (cnt_q == step_len - 8'h01);
  wire  [9:0] mask     = 10'h001 << bit_q;
  // ladder compare: keep the trial bit while input is at or above the tap
  wire  [9:0] kept     = comp_q ? code_q : (code_q & ~mask);

  ////////////////////////////////////////////////////////////////////////////
  // comparator crosses from the analog side, so two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_meta_q <= 1'b0;
      comp_q      <= 1'b0;
    end else begin
      comp_meta_q <= comparator_out;
      comp_q      <= comp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ten-bit approximation, msb trial first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      bit_q    <= 4'h0;
      cnt_q    <= 8'h00;
      code_q   <= 10'h000;
      result_q <= 10'h000;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (link.abort) begin
        active_q <= 1'b0;
      end else if (link.start && !active_q) begin
        active_q <= 1'b1;
        bit_q    <= 4'h9;
        cnt_q    <= 8'h00;
        code_q   <= 10'h200;
      end else if (step_end) begin
        cnt_q <= 8'h00;
        if (bit_q == 4'h0) begin
          result_q <= kept;
          done_q   <= 1'b1;
          active_q <= 1'b0;
        end else begin
          code_q <= kept | (mask >> 1);
          bit_q  <= bit_q - 4'h1;
        end
      end else if (active_q) begin
        // step length picks the conversion time
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign ladder_code       = code_q;
  assign comparator_enable = active_q;
  assign link.done         = done_q;
  assign link.result       = result_q;

endmodule // sar_engine

`default_nettype wire

// File: src/adc_sequencer_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

module adc_sequencer_control (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    halt_req,
  input  wire logic                    comparator_out,
  output adc_seq_pkg::chan_type        analog_channel_select,
  output logic      [9:0]              ladder_code,
  output logic                         comparator_enable,
  output logic                         conversion_done_interrupt
);
  import adc_seq_pkg::*;

  sar_link_if link ();

  sar_engine sar_engine_inst (
    .pclk              (pclk),
    .presetn           (presetn),
    .comparator_out    (comparator_out),
    .ladder_code       (ladder_code),
    .comparator_enable (comparator_enable),
    .link              (link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  seq_state_type state_q;
  chan_type      chan_field_q;
  logic          scan_q;
  logic          repeat_q;
  logic          speed_q;
  logic          end_flag_q;
  logic          busy_q;
  logic          run_repeat_q;
  chan_type      cur_ch_q;
  logic          start_q;
  logic          irq_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  result_type    res_word [4];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire [7:0] word_idx   = paddr[9:2];
  wire       in_window  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  wire       hit_mode   = in_window && (word_idx == `IDX_MODE);
  wire       hit_result = in_window && (word_idx >= `IDX_CH0_LOW) &&
                          (word_idx <= `IDX_CH3_HIGH);
  wire       mapped     = hit_mode || hit_result;
  // the completing edge of an access: only here do effects happen
  wire       acc_done   = psel && penable && pready_q;
  wire       acc_first  = psel && penable && !pready_q;
  wire       wr_mode    = acc_done && pwrite && hit_mode;
  wire       rd_result  = acc_done && !pwrite && hit_result;

  wire       start_req  = wr_mode && pwdata[`MODE_START_BIT];
  // start ignored while busy; halt also blocks a start
  wire       launch     = start_req && !busy_q && !halt_req;

  wire       new_scan   = pwdata[`MODE_SCAN_BIT];
  wire [1:0] new_ch     = pwdata[`MODE_CH_HI:`MODE_CH_LO];
  // scan always starts at channel 0
  wire [1:0] launch_ch  = new_scan ? 2'h0 : new_ch;
  wire [1:0] first_ch   = scan_q ? 2'h0 : chan_field_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing decisions at each conversion end

  wire conv_done  = (state_q == st_convert) && link.done;
  // fixed mode ends after its one channel
  wire seq_last   = !scan_q || (cur_ch_q == chan_field_q);
  // repeat cleared: leave once the conversion in progress is done
  wire rep_exit   = conv_done && run_repeat_q && !repeat_q;
  wire go_next    = conv_done && !rep_exit && !seq_last;
  // repeat reruns the channel or the whole scan
  wire go_rerun   = conv_done && !rep_exit && seq_last && repeat_q;
  wire finish     = conv_done && !go_next && !go_rerun;
  wire end_set    = finish || go_rerun;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  wire [1:0] sel_ch   = word_idx[2:1];
  wire       sel_high = word_idx[0];
  result_type sel_res;
  assign sel_res = res_word[sel_ch];

  // byte layout of a result pair
  wire [7:0] res_low  = {sel_res[1:0], `LOW_FILL};
  wire [7:0] res_high = sel_res[9:2];

  wire [7:0] mode_byte = {end_flag_q, busy_q, repeat_q, scan_q, speed_q,
                          1'b0, chan_field_q};

  wire [7:0] read_byte = hit_mode   ? mode_byte :
                         hit_result ? (sel_high ? res_high : res_low) :
                         8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, everything from flops

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
      if (acc_first) begin
        prdata_q  <= {24'h00_0000, read_byte};
        pslverr_q <= !mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_field_q <= `MODE_CH_RESET;
      scan_q       <= 1'b0;
      repeat_q     <= 1'b0;
      speed_q      <= 1'b0;
    end else if (wr_mode) begin
      chan_field_q <= new_ch;
      scan_q       <= new_scan;
      repeat_q     <= pwdata[`MODE_REPEAT_BIT];
      speed_q      <= pwdata[`MODE_SPEED_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end flag: a set in the same cycle as a clearing read wins

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_flag_q <= 1'b0;
    end else begin
      end_flag_q <= end_set || (end_flag_q && !rd_result);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= st_idle;
      busy_q       <= 1'b0;
      run_repeat_q <= 1'b0;
      cur_ch_q     <= 2'h0;
      start_q      <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      start_q <= 1'b0;
      irq_q   <= 1'b0;
      if (halt_req) begin
        // halt drops the run; nothing restarts it on release
        state_q <= st_idle;
        busy_q  <= 1'b0;
      end else begin
        unique case (state_q)
          st_idle: begin
            if (launch) begin
              // start sets busy and launches the first channel
              state_q      <= st_convert;
              busy_q       <= 1'b1;
              run_repeat_q <= pwdata[`MODE_REPEAT_BIT];
              cur_ch_q     <= launch_ch;
              start_q      <= 1'b1;
            end
          end
          st_convert: begin
            if (go_next) begin
              cur_ch_q <= cur_ch_q + 2'h1;
              start_q  <= 1'b1;
            end else if (go_rerun) begin
              cur_ch_q <= first_ch;
              start_q  <= 1'b1;
            end else if (finish) begin
              // end of single run clears busy and raises request
              state_q <= st_idle;
              busy_q  <= 1'b0;
              irq_q   <= !run_repeat_q;
            end
          end
        endcase
      end
    end
  end

  assign link.start = start_q;
  // engine aborts in the same cycle as the halt
  assign link.abort = halt_req;
  assign link.slow  = speed_q;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel results: no reset, content undefined until written

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_result
      result_type keep_q;
      // each channel stores its own result, every conversion
      // bus writes never reach this store
      always_ff @(posedge pclk) begin
        if (conv_done && (cur_ch_q == 2'(gi))) begin
          keep_q <= link.result;
        end
      end
      assign res_word[gi] = keep_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign analog_channel_select     = cur_ch_q;
  assign conversion_done_interrupt = irq_q;

endmodule // adc_sequencer_control

`default_nettype wire

// File: verif/analog_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
  input  wire logic                  pclk,
  input  wire adc_seq_pkg::chan_type analog_channel_select,
  input  wire logic [9:0]            ladder_code,
  input  wire logic                  comparator_enable,
  input  wire logic [39:0]           levels,
  output wire logic                  comparator_out
);
  import adc_seq_pkg::*;
  logic       wander_q = 1'b0;
  wire  [9:0] level_sel = levels[10 * int'(analog_channel_select) +: 10];
  // idle comparator wanders so nothing leans on a stale level
  always @(posedge pclk) wander_q <= ~wander_q;
  assign comparator_out = comparator_enable ? (level_sel >= ladder_code)
                                            : wander_q;
endmodule // analog_front_model
`default_nettype wire

// File: verif/adc_seq_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_seq_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  halt_req,
  input wire logic                  comparator_out,
  input wire adc_seq_pkg::chan_type analog_channel_select,
  input wire logic [9:0]            ladder_code,
  input wire logic                  comparator_enable,
  input wire logic                  conversion_done_interrupt
);
  import adc_seq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire low_read = pready && !pwrite && paddr[11:5] == 7'h0c
                  && paddr[2:0] == 3'h0;
  wire start_wr = pready && pwrite && pwdata[2]
                  && paddr == 12'({`IDX_MODE, 2'b00});
  sequence one_wait;
    !pready ##1 pready ##1 !pready;
  endsequence
  ////////////////////////////////////////
  a_apb_one_wait:
    assert property ($rose(penable) && psel |-> one_wait)
    else $error("apb answer not after one wait state");
  a_err_with_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_low_fill:
    assert property (low_read |-> prdata[31:8] == 24'h0
                     && prdata[5:0] == `LOW_FILL)
    else $error("low result byte filler wrong");
  a_start_runs:
    assert property (start_wr && !halt_req && !comparator_enable
                     |-> ##[1:3] comparator_enable)
    else $error("start write did not launch a conversion");
  a_first_trial:
    assert property ($rose(comparator_enable) |-> ladder_code == 10'h200)
    else $error("first trial not at mid ladder");
  a_step_hold:
    assert property (@(posedge pclk) disable iff (!presetn || halt_req)
      comparator_enable && $past(comparator_enable) && $changed(ladder_code)
      && ladder_code != 10'h200 |=> $stable(ladder_code) [*3])
    else $error("bit trial shorter than a step");
  a_chan_steady:
    assert property (comparator_enable && $past(comparator_enable)
                     && $stable(ladder_code) |-> $stable(analog_channel_select))
    else $error("channel changed inside a trial");
  a_irq_pulse:
    assert property (conversion_done_interrupt |=> !conversion_done_interrupt)
    else $error("done request longer than one cycle");
  a_irq_idle:
    assert property (conversion_done_interrupt |-> !comparator_enable)
    else $error("done request while converting");
  a_halt_stop:
    assert property (halt_req [*3] |-> !comparator_enable)
    else $error("converter runs during halt");
endmodule // adc_seq_checker
bind adc_sequencer_control adc_seq_checker adc_seq_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
  .comparator_out(comparator_out),
  .analog_channel_select(analog_channel_select),
  .ladder_code(ladder_code), .comparator_enable(comparator_enable),
  .conversion_done_interrupt(conversion_done_interrupt));
`default_nettype wire

// File: verif/test_adc_sequencer_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module test_adc_sequencer_control;
  import adc_seq_pkg::*;
  localparam logic [11:0] mode_addr = 12'({`IDX_MODE, 2'b00});
  localparam logic [11:0] res_addr  = 12'({`IDX_CH0_LOW, 2'b00});
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        halt_req = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [39:0] levels = 40'h0;
  logic [31:0] prdata, rd, m;
  logic        pready, pslverr, er, comparator_out, comparator_enable;
  logic        conversion_done_interrupt;
  chan_type    analog_channel_select;
  logic [9:0]  ladder_code;
  int          num_errors = 0, n_checks = 0, cyc;

  always #20 pclk = ~pclk;

  adc_sequencer_control adc_sequencer_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .comparator_out(comparator_out),
    .analog_channel_select(analog_channel_select),
    .ladder_code(ladder_code), .comparator_enable(comparator_enable),
    .conversion_done_interrupt(conversion_done_interrupt));
  analog_front_model analog_front_model_inst (
    .pclk(pclk), .analog_channel_select(analog_channel_select),
    .ladder_code(ladder_code), .comparator_enable(comparator_enable),
    .levels(levels), .comparator_out(comparator_out));
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one idle edge after release, so a next call never reassigns psel
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      num_errors++;
      end_sim();
    end
  endtask
  task wait_irq;
    cyc = 0;
    while (conversion_done_interrupt !== 1'b1 && cyc < 400) begin
      @(posedge pclk);
      cyc++;
    end
    if (cyc >= 400) begin
      num_errors++;
      end_sim();
    end
  endtask
  function automatic logic [9:0] lvl(input int c);
    return levels[c*10 +: 10];
  endfunction
  task res(input int c, input logic [9:0] v);
    apb(1'b0, res_addr + 12'(c * 8), 32'h0);
    chk("result low", rd, {24'h0, v[1:0], `LOW_FILL});
    apb(1'b0, res_addr + 12'(c * 8 + 4), 32'h0);
    chk("result high", rd, {24'h0, v[9:2]});
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, mode_addr, 32'h0);
    chk("mode reset", rd, 32'h0);
    chk("channel reset", 32'(analog_channel_select), 32'h0);
    apb(1'b0, 12'h1fc, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    levels <= {10'h3ff, 10'h155, 10'h000, 10'h2aa};
    // odd channels run slow, even ones fast
    for (int c = 0; c < 4; c++) begin
      m = 32'(c) | (32'(c % 2) << 3);
      apb(1'b1, mode_addr, m | 32'h4);
      wait_irq();
      chk("slow run", 32'(cyc > 100), 32'(c % 2));
      apb(1'b0, mode_addr, 32'h0);
      chk("mode at end", rd, m | 32'h80);
      res(c, lvl(c));
      apb(1'b0, mode_addr, 32'h0);
      chk("end cleared", rd, m);
    end
    apb(1'b1, res_addr, 32'h0);
    res(0, 10'h2aa);
    levels[29:10] <= {10'h321, 10'h0f0};
    apb(1'b1, mode_addr, 32'h6);
    apb(1'b1, mode_addr, 32'h5);
    wait_irq();
    res(1, 10'h000);
    res(2, 10'h321);
    levels <= {10'h111, 10'h222, 10'h333, 10'h044};
    apb(1'b1, mode_addr, 32'h16);
    wait_irq();
    for (int c = 0; c < 4; c++) res(c, c < 3 ? lvl(c) : 10'h3ff);
    apb(1'b1, mode_addr, 32'h2f); // no done request relied on
    repeat (400) @(posedge pclk);
    levels[39:30] <= 10'h137;
    repeat (400) @(posedge pclk);
    res(3, 10'h137);
    apb(1'b1, mode_addr, 32'h0b);
    apb(1'b0, mode_addr, 32'h0);
    chk("repeat tail busy", 32'(rd[6]), 32'h1);
    cyc = 0;
    while (rd[6] !== 1'b0 && cyc < 100) begin
      apb(1'b0, mode_addr, 32'h0);
      cyc++;
    end
    chk("repeat ended", 32'(rd[6]), 32'h0);
    apb(1'b1, mode_addr, 32'h35);
    levels[19:0] <= {10'h1e1, 10'h0c3};
    repeat (300) @(posedge pclk);
    res(0, 10'h0c3);
    res(1, 10'h1e1);
    halt_req <= 1'b1;
    repeat (5) @(posedge pclk);
    halt_req <= 1'b0;
    repeat (100) @(posedge pclk);
    chk("halt no resume", 32'(comparator_enable), 32'h0);
    apb(1'b0, mode_addr, 32'h0);
    chk("halt busy", 32'(rd[6]), 32'h0);
    end_sim();
  end
endmodule // test_adc_sequencer_control
`default_nettype wire
